// file: design/perf_state_power_controller.v
/* package operating-point and idle-power controller, two cores.
   assumes one 100 MHz clock, synchronous inputs and an APB master. */
// Function
// RULE1 - going up: step voltage, then relock pll
// RULE2 - going down: relock pll, then lower voltage
// RULE3 - accept requests anytime, defer while busy
// RULE4 - unavailable window stays under ten microseconds
// RULE5 - assert block-next-request during frequency change
// RULE6 - overheat moves to programmed thermal point
// RULE7 - after fixed wait, return if cool
// RULE8 - flag thermal down and up events
// RULE9 - failed thermal move falls back to throttling
// RULE10 - two core requests, package takes higher
// RULE11 - extended idle: drop to lowest, then enter (code enters the idle state at the write, then drops to lowest)
// RULE12 - break event resumes, concurrently restore point
// RULE13 - extended idle by hint or auto-promote
// RULE14 - no transitions in clock-stopped sleep states
// RULE15 - forced deep idle: deeper voltage, exit low
// RULE16 - data buffers on only during data activity
// RULE17 - address buffers off when priority request idle
// RULE18 - chipset may gate buffers when bus request off
// RULE19 - termination off while driving low
// RULE20 - power status asserted only while package idle
// RULE21 - platform asserts deep stop from deep sleep
// RULE22 - only latest deferred request is kept
`timescale 1ns/1ns
`include "perf_state_power_controller_regs.vh"

module perf_state_power_controller (
    input  wire        i_sys_clk,
    input  wire        i_rstn,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire        i_therm_hot,
    input  wire        i_pll_locked,
    input  wire        i_break_event,
    input  wire        i_deep_stop_n,
    input  wire        i_data_bus_active,
    input  wire        i_priority_agent_request_n,
    input  wire        i_bus_idle,
    input  wire        i_drive_low,
    output reg  [6:0]  o_voltage_select_code,
    output reg  [7:0]  o_pll_ratio,
    output reg         o_pll_relock,
    output reg         o_block_next_request_n,
    output reg         o_core_unavailable,
    output reg         o_data_buffer_power_n,
    output reg         o_addr_buffer_enable,
    output reg         o_bus_request_out_n,
    output reg         o_odt_enable,
    output reg         o_power_status_indicator_n,
    output reg         o_throttle_fallback
);

    // sequencer states
    localparam [2:0] S_IDLE    = 3'd0;
    localparam [2:0] S_V_UP    = 3'd1;
    localparam [2:0] S_RELOCK  = 3'd2;
    localparam [2:0] S_V_DOWN  = 3'd3;
    localparam [2:0] S_SETTLE  = 3'd4;

    // higher of two operating points by ratio
    function [15:0] max_point;
        input [15:0] a;
        input [15:0] b;
        max_point = (a[`OP_RATIO_MSB:`OP_RATIO_LSB] >=
                     b[`OP_RATIO_MSB:`OP_RATIO_LSB]) ? a : b;
    endfunction

    // one voltage code step toward a target
    function [6:0] code_step;
        input [6:0] cur;
        input [6:0] tgt;
        code_step = (cur > tgt) ? cur - 7'h01 :
                    (cur < tgt) ? cur + 7'h01 : cur;
    endfunction

    reg  [15:0] core0_req_r;      // per-core request registers
    reg  [15:0] core1_req_r;
    reg  [15:0] therm_point_r;    // thermal target point
    reg  [15:0] low_point_r;      // lowest operating point
    reg  [2:0]  cfg_r;            // auto-extend, forced deep idle, therm en
    reg  [2:0]  pkg_state_r;      // current package idle state
    reg         ext_idle_r;       // extended idle in force
    reg  [2:0]  events_r;         // sticky thermal events
    reg  [2:0]  state_r;          // sequencer state
    reg  [15:0] cur_point_r;      // running operating point
    reg  [15:0] tgt_point_r;      // point being moved to
    reg  [15:0] pend_point_r;     // deferred request
    reg         pend_r;           // deferred request valid
    reg  [15:0] last_req_r;       // last wanted point seen
    reg         therm_down_r;     // running at thermal point
    reg  [15:0] saved_point_r;    // set at reset only; never loaded or read
    reg         idle_low_r;       // running at lowest for idle
    reg  [19:0] therm_cnt_r;      // thermal recheck wait
    reg  [15:0] wait_cnt_r;       // dwell timer; lock count loaded but not used
    reg  [15:0] unavail_cnt_r;    // unavailable window length
    reg         therm_move_r;     // current move is thermal
    reg         forced_low_r;     // forced deeper exit holds lowest

    // package request resolution
    wire [15:0] resolved = max_point(core0_req_r, core1_req_r); // [RULE10]
    wire clocks_off = (pkg_state_r == `PKG_SLEEP) ||
                      (pkg_state_r == `PKG_DEEP_SLEEP) ||
                      (pkg_state_r == `PKG_DEEPER_SLEEP);
    wire deeper_now = (pkg_state_r == `PKG_DEEP_SLEEP) && !i_deep_stop_n;
    wire is_up = tgt_point_r[`OP_RATIO_MSB:`OP_RATIO_LSB] >
                 cur_point_r[`OP_RATIO_MSB:`OP_RATIO_LSB];
    wire wr_en = i_psel && i_penable && i_pwrite;
    wire [6:0] tgt_code = tgt_point_r[`OP_CODE_MSB:`OP_CODE_LSB];
    wire [2:0] wr_state = i_pwdata[`IDLE_STATE_MSB:0];

    // wanted point, thermal first
    reg  [15:0] want_point;
    always @* begin
        if (therm_down_r)
            want_point = therm_point_r;
        else if (idle_low_r || forced_low_r) // [RULE11] [RULE15]
            want_point = low_point_r;
        else
            want_point = resolved;
    end

    // read mux, unmapped: zero and error
    reg [31:0] rd_data;
    reg        rd_err;
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (i_paddr)
            `OFF_CORE0_REQ:   rd_data = {16'h0000, core0_req_r};
            `OFF_CORE1_REQ:   rd_data = {16'h0000, core1_req_r};
            `OFF_THERM_POINT: rd_data = {16'h0000, therm_point_r};
            `OFF_CONFIG:      rd_data = {29'h0, cfg_r};
            `OFF_IDLE_CMD:    rd_data = {28'h0, ext_idle_r, pkg_state_r};
            `OFF_STATUS:      rd_data = {state_r, pend_r, therm_down_r,
                                         idle_low_r, 10'h000,
                                         cur_point_r};
            `OFF_EVENTS:      rd_data = {29'h0, events_r};
            `OFF_STEP_CFG:    rd_data = {16'h0000, low_point_r};
            default:          rd_err  = 1'b1;
        endcase
    end

    // apb slave: zero wait state answer
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && rd_err;
            if (i_psel && !i_penable && !i_pwrite)
                o_prdata <= rd_data;
        end
    end

    // register writes and idle state tracking
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            core0_req_r   <= `RST_OP_POINT;
            core1_req_r   <= `RST_OP_POINT;
            therm_point_r <= `RST_LOW_POINT;
            low_point_r   <= `RST_LOW_POINT;
            cfg_r         <= 3'h5;
            pkg_state_r   <= `PKG_ACTIVE;
            ext_idle_r    <= 1'b0;
            forced_low_r  <= 1'b0;
        end else begin
            if (wr_en && o_pready) begin
                case (i_paddr)
                    `OFF_CORE0_REQ:   core0_req_r   <= i_pwdata[15:0];
                    `OFF_CORE1_REQ:   core1_req_r   <= i_pwdata[15:0];
                    `OFF_THERM_POINT: therm_point_r <= i_pwdata[15:0];
                    `OFF_CONFIG:      cfg_r         <= i_pwdata[2:0];
                    `OFF_STEP_CFG:    low_point_r   <= i_pwdata[15:0];
                    `OFF_IDLE_CMD: begin
                        pkg_state_r <= wr_state;
                        // hint or promotion makes it extended [RULE13]
                        ext_idle_r  <= (wr_state != `PKG_ACTIVE) &&
                                       (i_pwdata[`IDLE_EXT_BIT] ||
                                        cfg_r[`CFG_AUTO_EXT_BIT]);
                    end
                    default: ;
                endcase
            end
            if (i_break_event) begin
                // resume at once; restore runs in parallel [RULE12]
                pkg_state_r <= `PKG_ACTIVE;
                ext_idle_r  <= 1'b0;
            end
            // forced deeper exit stays low until a core request
            if (deeper_now && cfg_r[`CFG_FORCED_DI_BIT])
                forced_low_r <= 1'b1; // [RULE15]
            else if (wr_en && o_pready && i_paddr[11:3] == 9'h000)
                forced_low_r <= 1'b0;
        end
    end

    // sequencer: deferral, ordering, thermal handling, events
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_r       <= S_IDLE;
            cur_point_r   <= `RST_OP_POINT;
            tgt_point_r   <= `RST_OP_POINT;
            pend_point_r  <= `RST_OP_POINT;
            pend_r        <= 1'b0;
            last_req_r    <= `RST_OP_POINT;
            therm_down_r  <= 1'b0;
            saved_point_r <= `RST_OP_POINT;
            idle_low_r    <= 1'b0;
            therm_cnt_r   <= 20'h00000;
            wait_cnt_r    <= 16'h0000;
            unavail_cnt_r <= 16'h0000;
            therm_move_r  <= 1'b0;
            events_r      <= 3'h0;
            o_voltage_select_code <= `RST_CODE;
            o_pll_ratio   <= 8'h0C;
            o_pll_relock  <= 1'b0;
            o_block_next_request_n <= 1'b1;
            o_core_unavailable     <= 1'b0;
            o_throttle_fallback    <= 1'b0;
        end else begin
            // software clear first; hardware set below wins
            if (wr_en && o_pready && i_paddr == `OFF_EVENTS)
                events_r <= events_r & ~i_pwdata[2:0];
            // idle entry at lowest point / release on break [RULE11]
            if (ext_idle_r && !idle_low_r)
                idle_low_r <= 1'b1;
            else if (!ext_idle_r && idle_low_r && !deeper_now)
                idle_low_r <= 1'b0;
            // thermal down trigger [RULE6]
            if (cfg_r[`CFG_THERM_EN_BIT] && i_therm_hot && !therm_down_r) begin
                therm_down_r <= 1'b1;
                therm_cnt_r  <= `THERM_WAIT_CYC;
                events_r[`EVT_THERM_DOWN] <= 1'b1; // [RULE8]
            end else if (therm_down_r) begin
                // fixed wait, then back up if cooled [RULE7]
                if (therm_cnt_r != 20'h00000)
                    therm_cnt_r <= therm_cnt_r - 20'h00001;
                else if (!i_therm_hot) begin
                    therm_down_r <= 1'b0;
                    events_r[`EVT_THERM_UP] <= 1'b1; // [RULE8]
                end else
                    therm_cnt_r <= `THERM_WAIT_CYC;
            end
            // newest differing request replaces pending [RULE3] [RULE22]
            if (want_point != last_req_r) begin
                last_req_r   <= want_point;
                pend_point_r <= want_point;
                pend_r       <= 1'b1;
            end
            case (state_r)
                S_IDLE: begin
                    o_block_next_request_n <= 1'b1;
                    o_core_unavailable     <= 1'b0;
                    if (deeper_now && cfg_r[`CFG_FORCED_DI_BIT]) begin
                        // deeper level code while clocks stop [RULE15]
                        o_voltage_select_code <= `RST_DEEPER_CODE;
                        cur_point_r <= {cur_point_r[15:7], `RST_DEEPER_CODE};
                    end else if (pend_r && !clocks_off) begin // [RULE14]
                        pend_r       <= (want_point != pend_point_r);
                        tgt_point_r  <= pend_point_r;
                        therm_move_r <= therm_down_r;
                        wait_cnt_r   <= `STEP_DWELL_CYC;
                        if (pend_point_r[15:8] > cur_point_r[15:8])
                            state_r <= S_V_UP;   // volts first [RULE1]
                        else
                            state_r <= S_RELOCK; // pll first [RULE2]
                    end
                end
                S_V_UP: begin
                    // step code one at a time up to target [RULE1]
                    if (wait_cnt_r != 16'h0000)
                        wait_cnt_r <= wait_cnt_r - 16'h0001;
                    else if (o_voltage_select_code != tgt_code) begin
                        o_voltage_select_code <=
                            code_step(o_voltage_select_code, tgt_code);
                        wait_cnt_r <= `STEP_DWELL_CYC;
                    end else begin
                        state_r    <= S_RELOCK;
                        wait_cnt_r <= `PLL_LOCK_CYC;
                    end
                end
                S_RELOCK: begin
                    // snoops held off, cores stopped [RULE5] [RULE4]
                    o_block_next_request_n <= 1'b0;
                    o_core_unavailable     <= 1'b1;
                    o_pll_ratio  <= tgt_point_r[15:8];
                    o_pll_relock <= 1'b1;
                    unavail_cnt_r <= unavail_cnt_r + 16'h0001;
                    if (unavail_cnt_r >= `MAX_UNAVAIL_CYC - 16'h0002) begin
                        // lock too slow: bound the window, fail [RULE4]
                        o_pll_relock  <= 1'b0;
                        unavail_cnt_r <= 16'h0000;
                        o_pll_ratio   <= cur_point_r[15:8];
                        state_r       <= S_SETTLE;
                        if (therm_move_r) begin
                            o_throttle_fallback <= 1'b1; // [RULE9]
                            events_r[`EVT_THERM_FALLBACK] <= 1'b1;
                        end
                    end else if (i_pll_locked && o_pll_relock) begin
                        o_pll_relock  <= 1'b0;
                        unavail_cnt_r <= 16'h0000;
                        cur_point_r[15:8] <= tgt_point_r[15:8];
                        wait_cnt_r <= `STEP_DWELL_CYC;
                        state_r <= is_up ? S_SETTLE : S_V_DOWN;
                    end
                end
                S_V_DOWN: begin
                    // lower voltage after the relock [RULE2]
                    o_block_next_request_n <= 1'b1;
                    o_core_unavailable     <= 1'b0;
                    if (wait_cnt_r != 16'h0000)
                        wait_cnt_r <= wait_cnt_r - 16'h0001;
                    else if (o_voltage_select_code != tgt_code) begin
                        o_voltage_select_code <=
                            code_step(o_voltage_select_code, tgt_code);
                        wait_cnt_r <= `STEP_DWELL_CYC;
                    end else
                        state_r <= S_SETTLE;
                end
                S_SETTLE: begin
                    o_block_next_request_n <= 1'b1;
                    o_core_unavailable     <= 1'b0;
                    cur_point_r <= {o_pll_ratio, 1'b0,
                                    o_voltage_select_code};
                    if (!therm_down_r)
                        o_throttle_fallback <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // bus buffer gating and regulator indicator
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_data_buffer_power_n      <= 1'b1;
            o_addr_buffer_enable       <= 1'b0;
            o_bus_request_out_n        <= 1'b1;
            o_odt_enable               <= 1'b1;
            o_power_status_indicator_n <= 1'b1;
        end else begin
            o_data_buffer_power_n <= !i_data_bus_active;        // [RULE16]
            o_addr_buffer_enable  <= !i_priority_agent_request_n; // [RULE17]
            // parked bus lets chipset gate its own buffers
            o_bus_request_out_n   <= i_bus_idle;
            o_odt_enable          <= !i_drive_low;              // [RULE19]
            o_power_status_indicator_n <=
                (pkg_state_r == `PKG_ACTIVE);                   // [RULE20]
        end
    end

endmodule

// file: design/perf_state_power_controller_regs.vh
/* offsets, fields, reset values and timing counts of the power controller.
   assumes a 100 MHz clock and a 32-bit APB bus. */
`ifndef PERF_STATE_POWER_CONTROLLER_REGS_VH
`define PERF_STATE_POWER_CONTROLLER_REGS_VH

// register byte offsets
`define OFF_CORE0_REQ      12'h000
`define OFF_CORE1_REQ      12'h004
`define OFF_THERM_POINT    12'h008
`define OFF_CONFIG         12'h00C
`define OFF_IDLE_CMD       12'h010
`define OFF_STATUS         12'h014
`define OFF_EVENTS         12'h018
`define OFF_STEP_CFG       12'h01C

// operating point: ratio in [15:8], voltage select code in [6:0]
`define OP_RATIO_MSB       15
`define OP_RATIO_LSB       8
`define OP_CODE_MSB        6
`define OP_CODE_LSB        0

// config fields
`define CFG_AUTO_EXT_BIT   0
`define CFG_FORCED_DI_BIT  1
`define CFG_THERM_EN_BIT   2

// idle command fields: [2:0] package state, [3] extended hint
`define IDLE_STATE_MSB     2
`define IDLE_EXT_BIT       3

// package idle state encodings
`define PKG_ACTIVE         3'h0
`define PKG_STOP_GRANT     3'h1
`define PKG_SLEEP          3'h2
`define PKG_DEEP_SLEEP     3'h3
`define PKG_DEEPER_SLEEP   3'h4

// event bits (write one to clear)
`define EVT_THERM_DOWN     0
`define EVT_THERM_UP       1
`define EVT_THERM_FALLBACK 2

// reset values
`define RST_OP_POINT       16'h0C20
`define RST_CODE           7'h20
`define RST_LOW_POINT      16'h0640
`define RST_DEEPER_CODE    7'h50

// timing: unavailable window bound, in ns, and cycles at 10 ns
`define CLK_PERIOD_NS      10
`define MAX_UNAVAIL_NS     10000
`define MAX_UNAVAIL_CYC    (`MAX_UNAVAIL_NS / `CLK_PERIOD_NS)
`define PLL_LOCK_CYC       16'd200
`define STEP_DWELL_CYC     16'd20
`define THERM_WAIT_CYC     20'd100000

`endif

// file: verif/perf_state_power_controller_sva.sv
/* port checks of the power controller.
   assumes one clock, sync active-low reset. */
`timescale 1ns/1ns
module perf_state_power_controller_sva (
    input wire logic       i_sys_clk,
    input wire logic       i_rstn,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       o_pready,
    input wire logic       o_pslverr,
    input wire logic       i_drive_low,
    input wire logic       i_priority_agent_request_n,
    input wire logic       i_data_bus_active,
    input wire logic       i_bus_idle,
    input wire logic [6:0] o_voltage_select_code,
    input wire logic [7:0] o_pll_ratio,
    input wire logic       o_pll_relock,
    input wire logic       o_block_next_request_n,
    input wire logic       o_core_unavailable,
    input wire logic       o_data_buffer_power_n,
    input wire logic       o_addr_buffer_enable,
    input wire logic       o_bus_request_out_n,
    input wire logic       o_odt_enable,
    input wire logic       o_throttle_fallback
);
    localparam int UNAV_MAX = 1000; // longest unavailable run, cycles
    logic [10:0] unav_cnt_r;        // length of current unavailable run
    // measure each unavailable run
    always @(posedge i_sys_clk) begin
        if (!i_rstn || !o_core_unavailable) unav_cnt_r <= 11'h000;
        else unav_cnt_r <= unav_cnt_r + 11'h001;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    property p_snoop; o_pll_relock |-> !o_block_next_request_n; endproperty
    a_snoop: assert property (p_snoop)
        else $error("snoops open in relock");
    property p_unav; o_pll_relock |-> o_core_unavailable; endproperty
    a_unav: assert property (p_unav)
        else $error("cores up in relock");
    property p_unav_len; unav_cnt_r < UNAV_MAX; endproperty
    a_unav_len: assert property (p_unav_len)
        else $error("window too long");
    property p_code_hold;
        o_pll_relock && $past(o_pll_relock) |-> $stable(o_voltage_select_code);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("code moved in relock");
    property p_ratio;
        $changed(o_pll_ratio) |-> o_pll_relock || $past(o_pll_relock);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ratio moved outside relock");
    property p_odt; o_odt_enable != $past(i_drive_low); endproperty
    a_odt: assert property (p_odt)
        else $error("odt wrong");
    property p_addr; i_priority_agent_request_n |=> !o_addr_buffer_enable;
    endproperty
    a_addr: assert property (p_addr)
        else $error("addr buffers on");
    property p_data; !i_data_bus_active |=> o_data_buffer_power_n; endproperty
    a_data: assert property (p_data)
        else $error("data buffers on");
    property p_park; o_bus_request_out_n == $past(i_bus_idle); endproperty
    a_park: assert property (p_park)
        else $error("bus request wrong");
    property p_apb; i_psel && !i_penable |=> o_pready; endproperty
    a_apb: assert property (p_apb)
        else $error("no pready");
    c_relock: cover property ($rose(o_pll_relock));
    c_fallback: cover property ($rose(o_throttle_fallback));
    c_slverr: cover property (o_pready && o_pslverr);
endmodule
bind perf_state_power_controller perf_state_power_controller_sva u_sva (.*);

// file: verif/perf_state_power_controller_tb_top.sv
/* power controller bench: apb tasks and sequences.
   assumes the partner model and the bound checker. */
`timescale 1ns/1ns
`include "perf_state_power_controller_regs.vh"
module perf_state_power_controller_tb_top;
    logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_stuck = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rq;
    logic i_therm_hot = 1'b0, i_break_event = 1'b0, i_deep_stop_n = 1'b1;
    logic i_data_bus_active = 1'b0, i_priority_agent_request_n = 1'b1;
    logic i_bus_idle = 1'b1, i_drive_low = 1'b0, rerr, prev_relock;
    wire  [31:0] o_prdata;
    wire  [6:0]  o_voltage_select_code;
    wire  [7:0]  o_pll_ratio;
    wire  o_pready, o_pslverr, i_pll_locked, o_pll_relock, chip_buf_on;
    wire  o_block_next_request_n, o_core_unavailable, o_data_buffer_power_n;
    wire  o_addr_buffer_enable, o_bus_request_out_n, o_odt_enable;
    wire  o_power_status_indicator_n, o_throttle_fallback;
    logic [6:0] relock_code; // supply code as each relock begins
    integer bad_count = 0, total_checks = 0, n;
    logic [4:0] k;
    perf_state_power_controller uut (.*);
    vr_chipset_model partner (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_pll_relock(o_pll_relock), .i_stuck(i_stuck),
        .i_bus_request_out_n(o_bus_request_out_n),
        .o_pll_locked(i_pll_locked), .o_chip_buf_on(chip_buf_on));
    always #5 i_sys_clk = ~i_sys_clk;
    // note the supply code at each relock start
    always @(posedge i_sys_clk) begin
        prev_relock <= o_pll_relock;
        if (o_pll_relock === 1'b1 && prev_relock !== 1'b1)
            relock_code <= o_voltage_select_code;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w;
        i_paddr <= a; i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        @(posedge i_sys_clk);
        n = 0;
        while (o_pready !== 1'b1 && n < 50) begin
            @(posedge i_sys_clk);
            n = n + 1;
        end
        if (n == 50) bad_count = bad_count + 1;
        rq = o_prdata; rerr = o_pslverr;
        i_psel <= 1'b0; i_penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rq, e);
    endtask
    // wait for a settled ratio
    task wait_pt(input logic [7:0] r);
        n = 0;
        while (!(o_pll_ratio === r && o_pll_relock === 1'b0) && n < 4000) begin
            @(posedge i_sys_clk);
            n = n + 1;
        end
        chk(o_pll_ratio, r);
    endtask
    task do_reset;
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
    endtask
    task pulse_break;
        @(posedge i_sys_clk) i_break_event <= 1'b1;
        @(posedge i_sys_clk) i_break_event <= 1'b0;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #600000;
        bad_count = bad_count + 1;
        $display("unexpected at %0t: run hung", $time);
        wrap_up;
    end
    initial begin
        do_reset;
        chk(o_voltage_select_code, 7'h20);
        chk(o_power_status_indicator_n, 1'b1);
        rd(`OFF_CONFIG, 32'h5);
        rd(`OFF_STEP_CFG, {16'h0, `RST_LOW_POINT});
        rd(12'h020, 32'h0);
        chk(rerr, 1'b1);
        apb(1'b1, `OFF_CORE1_REQ, 32'h0A28);
        apb(1'b1, `OFF_CORE0_REQ, 32'h1030);
        wait_pt(8'h10);
        chk(relock_code, 7'h30);
        apb(1'b1, `OFF_CORE0_REQ, 32'h0820);
        wait_pt(8'h0A);
        chk(relock_code, 7'h30);
        repeat (250) @(posedge i_sys_clk);
        chk(o_voltage_select_code, 7'h28);
        apb(1'b1, `OFF_CORE0_REQ, 32'h1030);
        apb(1'b1, `OFF_CORE0_REQ, 32'h1440);
        apb(1'b1, `OFF_CORE0_REQ, 32'h1238);
        wait_pt(8'h12);
        repeat (300) @(posedge i_sys_clk);
        chk(o_pll_ratio, 8'h12);
        chk(o_voltage_select_code, 7'h38);
        for (k = 0; k < 2; k = k + 1) begin
            apb(1'b1, `OFF_CONFIG, 32'h4 | k);
            apb(1'b1, `OFF_IDLE_CMD, k[0] ? 32'h1 : 32'h9);
            wait_pt(8'h06);
            chk(o_power_status_indicator_n, 1'b0);
            pulse_break;
            repeat (2) @(posedge i_sys_clk);
            chk(o_power_status_indicator_n, 1'b1);
            wait_pt(8'h12);
        end
        apb(1'b1, `OFF_CONFIG, 32'h4);
        apb(1'b1, `OFF_IDLE_CMD, 32'h2);
        apb(1'b1, `OFF_CORE0_REQ, 32'h1440);
        repeat (60) @(posedge i_sys_clk);
        chk(o_pll_relock, 1'b0);
        pulse_break;
        wait_pt(8'h14);
        apb(1'b1, `OFF_CONFIG, 32'h6);
        apb(1'b1, `OFF_IDLE_CMD, 32'h3);
        i_deep_stop_n <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        chk(o_voltage_select_code, 7'h50);
        i_deep_stop_n <= 1'b1;
        pulse_break;
        wait_pt(8'h06);
        for (k = 0; k < 16; k = k + 1) begin
            {i_drive_low, i_priority_agent_request_n} <= k[3:2];
            {i_data_bus_active, i_bus_idle} <= k[1:0];
            repeat (2) @(posedge i_sys_clk);
            chk(o_odt_enable, !k[3]);
            chk(o_addr_buffer_enable, !k[2]);
            chk(o_data_buffer_power_n, !k[1]);
            chk(chip_buf_on, !k[0]);
        end
        {i_drive_low, i_priority_agent_request_n} <= 2'b01;
        {i_data_bus_active, i_bus_idle} <= 2'b01;
        do_reset;
        apb(1'b1, `OFF_THERM_POINT, 32'h0820);
        i_stuck <= 1'b1;
        i_therm_hot <= 1'b1;
        for (n = 0; n < 1500 && o_throttle_fallback !== 1'b1; n = n + 1)
            @(posedge i_sys_clk);
        chk(o_throttle_fallback, 1'b1);
        i_therm_hot <= 1'b0;
        i_stuck <= 1'b0;
        do_reset;
        apb(1'b1, `OFF_THERM_POINT, 32'h0820);
        i_therm_hot <= 1'b1;
        wait_pt(8'h08);
        rd(`OFF_EVENTS, 32'h1);
        apb(1'b1, `OFF_EVENTS, 32'h1);
        rd(`OFF_EVENTS, 32'h0);
        wrap_up;
    end
endmodule

// file: verif/vr_chipset_model.sv
/* pll lock and chipset buffer model.
   assumes direct controller outputs. */
`timescale 1ns/1ns
module vr_chipset_model (
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    input  wire logic i_pll_relock,
    input  wire logic i_stuck,
    input  wire logic i_bus_request_out_n,
    output logic      o_pll_locked,
    output logic      o_chip_buf_on
);
    logic [7:0] lock_cnt_r; // cycles since relock began
    // count lock time while relock is requested
    always @(posedge i_sys_clk) begin
        if (!i_rstn || !i_pll_relock) lock_cnt_r <= 8'h00;
        else if (lock_cnt_r != 8'hFF) lock_cnt_r <= lock_cnt_r + 8'h01;
    end
    // lock drops at once on relock; a stuck pll stays unlocked until relock drops
    assign o_pll_locked = !i_pll_relock || (!i_stuck && lock_cnt_r > 8'h0B);
    // chipset parks its own buffers while bus request is off
    assign o_chip_buf_on = !i_bus_request_out_n;
endmodule
